// >>> hw/bgp_consts.svh
`ifndef BGP_CONSTS_SVH
`define BGP_CONSTS_SVH

// Configuration dword that holds the port (byte address)
`define BGP_GPIO_OFFSET   8'h64
// Number of general-purpose pins
`define BGP_PINS          4
// Field positions inside the dword
`define BGP_CLR_LSB       8
`define BGP_SET_LSB       12
`define BGP_OECLR_LSB     16
`define BGP_OESET_LSB     20
`define BGP_RSVD_LSB      24
`define BGP_IN_LSB        28
// Reset value of every nibble of state
`define BGP_NIB_RESET     4'h0
// Value returned by the reserved nibble and unowned lanes
`define BGP_RSVD_VALUE    4'h0
`define BGP_LANE_ZERO     8'h00

`endif

// >>> hw/bgp_pkg.sv
package bgp_pkg;

    // One bit per general-purpose pin
    typedef logic [3:0] bgp_nib_type;

    // Kind of configuration access seen this cycle
    typedef enum logic [1:0]
    {
        BGP_ACC_NONE  = 2'b00,
        BGP_ACC_WRITE = 2'b01,
        BGP_ACC_READ  = 2'b10
    } bgp_acc_type;

endpackage

// >>> hw/bgp_gpio_port.sv
`timescale 1ns/100ps
`include "bgp_consts.svh"

module bgp_gpio_port
(
    input  wire logic                ref_clk,    // PCI clock, 100 MHz
    input  wire logic                rst,        // Synchronous bridge reset, high
    input  wire logic [7:0]          cfg_addr,   // Configuration byte address
    input  wire logic [3:0]          cfg_be,     // Byte enables of the dword
    input  wire logic [31:0]         cfg_wdata,  // Configuration write data
    input  wire logic                cfg_wr,     // Pulse: write transaction completes
    input  wire logic                cfg_rd,     // Pulse: read request
    output logic      [31:0]         cfg_rdata,  // Read data, registered
    output logic                     cfg_rack,   // Pulse: read data valid
    input  wire logic [3:0]          gpio_in,    // Pin levels, asynchronous
    output logic      [3:0]          gpio_out,   // Pin output value
    output logic      [3:0]          gpio_oe     // Pin output enable, high drives
);

    // Extract one nibble of write data, zero when its lane is off
    function automatic bgp_pkg::bgp_nib_type field_wr
    (
        input logic [31:0] wdata,
        input logic [3:0]  be,
        input int          lsb
    );
        logic [1:0] lane;
        lane = 2'(lsb >> 3);
        field_wr = be[lane] ? wdata[lsb +: 4] : `BGP_NIB_RESET;
    endfunction

    // Tell whether a nibble's byte lane is written
    function automatic logic lane_on
    (
        input logic [3:0] be,
        input int         lsb
    );
        logic [1:0] lane;
        lane = 2'(lsb >> 3);
        lane_on = be[lane];
    endfunction

    // Address hit on the port dword
    logic                    hit;
    // Access kind this cycle
    bgp_pkg::bgp_acc_type    acc;
    // Nibbles carried by a write to the port
    bgp_pkg::bgp_nib_type    wr_clr;
    bgp_pkg::bgp_nib_type    wr_set;
    bgp_pkg::bgp_nib_type    wr_oeclr;
    bgp_pkg::bgp_nib_type    wr_oeset;
    // Output data and output enable state
    bgp_pkg::bgp_nib_type    data_q;
    bgp_pkg::bgp_nib_type    data_d;
    bgp_pkg::bgp_nib_type    oe_q;
    bgp_pkg::bgp_nib_type    oe_d;
    // Last values written to the four write-one fields
    bgp_pkg::bgp_nib_type    clr_last_q;
    bgp_pkg::bgp_nib_type    clr_last_d;
    bgp_pkg::bgp_nib_type    set_last_q;
    bgp_pkg::bgp_nib_type    set_last_d;
    bgp_pkg::bgp_nib_type    oeclr_last_q;
    bgp_pkg::bgp_nib_type    oeclr_last_d;
    bgp_pkg::bgp_nib_type    oeset_last_q;
    bgp_pkg::bgp_nib_type    oeset_last_d;
    // Pin synchroniser stages
    bgp_pkg::bgp_nib_type    sync1_q;
    bgp_pkg::bgp_nib_type    sync1_d;
    bgp_pkg::bgp_nib_type    in_q;
    bgp_pkg::bgp_nib_type    in_d;
    // Read answer
    logic [31:0]             rdata_q;
    logic [31:0]             rdata_d;
    logic                    rack_q;
    logic                    rack_d;
    // Port dword address as a sized constant, so its dword bits can be sliced
    localparam logic [7:0]   port_addr = `BGP_GPIO_OFFSET;

    // Decode the access and pull out the written nibbles
    always_comb
    begin
        hit = (cfg_addr[7:2] == port_addr[7:2]);
        if (cfg_wr && hit)
        begin
            acc = bgp_pkg::BGP_ACC_WRITE;
        end
        else if (cfg_rd)
        begin
            acc = bgp_pkg::BGP_ACC_READ;
        end
        else
        begin
            acc = bgp_pkg::BGP_ACC_NONE;
        end
        if (acc == bgp_pkg::BGP_ACC_WRITE)
        begin
            wr_clr   = field_wr(cfg_wdata, cfg_be, `BGP_CLR_LSB);
            wr_set   = field_wr(cfg_wdata, cfg_be, `BGP_SET_LSB);
            wr_oeclr = field_wr(cfg_wdata, cfg_be, `BGP_OECLR_LSB);
            wr_oeset = field_wr(cfg_wdata, cfg_be, `BGP_OESET_LSB);
        end
        else
        begin
            wr_clr   = `BGP_NIB_RESET;
            wr_set   = `BGP_NIB_RESET;
            wr_oeclr = `BGP_NIB_RESET;
            wr_oeset = `BGP_NIB_RESET;
        end
    end

    // Next output data and direction; set wins over clear on one bit
    always_comb
    begin
        data_d = (data_q & ~wr_clr) | wr_set;
        oe_d = (oe_q & ~wr_oeclr) | wr_oeset;
        if (rst)
        begin
            data_d = `BGP_NIB_RESET;
            oe_d   = `BGP_NIB_RESET;
        end
    end

    // Register data and direction
    always_ff @(posedge ref_clk)
    begin
        data_q <= data_d;
        oe_q   <= oe_d;
    end

    // Remember the last nibble written to each write-one field
    always_comb
    begin
        clr_last_d   = clr_last_q;
        set_last_d   = set_last_q;
        oeclr_last_d = oeclr_last_q;
        oeset_last_d = oeset_last_q;
        if (rst)
        begin
            clr_last_d   = `BGP_NIB_RESET;
            set_last_d   = `BGP_NIB_RESET;
            oeclr_last_d = `BGP_NIB_RESET;
            oeset_last_d = `BGP_NIB_RESET;
        end
        else if (acc == bgp_pkg::BGP_ACC_WRITE)
        begin
            if (lane_on(cfg_be, `BGP_CLR_LSB))
            begin
                clr_last_d = wr_clr;
                set_last_d = wr_set;
            end
            if (lane_on(cfg_be, `BGP_OECLR_LSB))
            begin
                oeclr_last_d = wr_oeclr;
                oeset_last_d = wr_oeset;
            end
        end
    end

    // Register the readback nibbles
    always_ff @(posedge ref_clk)
    begin
        clr_last_q   <= clr_last_d;
        set_last_q   <= set_last_d;
        oeclr_last_q <= oeclr_last_d;
        oeset_last_q <= oeset_last_d;
    end

    // Two-stage pin synchroniser; only the second stage is read
    always_comb
    begin
        sync1_d = rst ? `BGP_NIB_RESET : gpio_in;
        in_d    = rst ? `BGP_NIB_RESET : sync1_q;
    end

    // Register the synchroniser
    always_ff @(posedge ref_clk)
    begin
        sync1_q <= sync1_d;
        in_q    <= in_d;
    end

    // Build the read answer; other dwords read as zero
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        rack_d  = 1'b0;
        if (!rst && acc == bgp_pkg::BGP_ACC_READ)
        begin
            rack_d = 1'b1;
            if (hit)
            begin
                rdata_d = {in_q, `BGP_RSVD_VALUE, oeset_last_q, oeclr_last_q,
                           set_last_q, clr_last_q, `BGP_LANE_ZERO};
            end
        end
    end

    // Register the read answer
    always_ff @(posedge ref_clk)
    begin
        rdata_q <= rdata_d;
        rack_q  <= rack_d;
    end

    // Pin drive comes straight from flops
    always_comb
    begin
        cfg_rdata = rdata_q;
        cfg_rack  = rack_q;
        gpio_out  = data_q;
        gpio_oe   = oe_q;
    end

    // Checks on the port behaviour
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // A write to the port that changes a pin's output value, whether or not its enable is set
    sequence s_level_write;
        acc == bgp_pkg::BGP_ACC_WRITE && ((wr_set & ~data_q) | (wr_clr & ~wr_set & data_q)) != 4'h0;
    endsequence

    // The driven level has moved by the next cycle
    sequence s_level_moved;
        ##1 gpio_out != $past(gpio_out);
    endsequence

    // Three cycles with no write, then a read of the port
    sequence s_quiet_read;
        (acc != bgp_pkg::BGP_ACC_WRITE)[*3] ##1 (acc == bgp_pkg::BGP_ACC_READ && hit);
    endsequence

    a_clear_drives_low: assert property (acc == bgp_pkg::BGP_ACC_WRITE |=>
        (gpio_out & $past(wr_clr) & ~$past(wr_set)) == 4'h0)
        else $error("clear write did not drive pin low");

    a_set_drives_high: assert property (acc == bgp_pkg::BGP_ACC_WRITE |=>
        (gpio_out & $past(wr_set)) == $past(wr_set))
        else $error("set write did not drive pin high");

    a_level_next_cycle: assert property (s_level_write |-> s_level_moved)
        else $error("pin level did not change the cycle after write");

    a_dir_only_on_write: assert property (acc != bgp_pkg::BGP_ACC_WRITE |=> $stable(gpio_oe))
        else $error("pin direction changed without a write");

    a_zero_keeps_out: assert property (acc == bgp_pkg::BGP_ACC_WRITE && wr_clr == 4'h0
        && wr_set == 4'h0 |=> $stable(gpio_out))
        else $error("zero data write changed output");

    a_enable_clear: assert property (acc == bgp_pkg::BGP_ACC_WRITE |=>
        (gpio_oe & $past(wr_oeclr) & ~$past(wr_oeset)) == 4'h0)
        else $error("enable clear left pin driven");

    a_enable_set: assert property (acc == bgp_pkg::BGP_ACC_WRITE |=>
        (gpio_oe & $past(wr_oeset)) == $past(wr_oeset))
        else $error("enable set did not drive pin");

    a_zero_keeps_dir: assert property (acc == bgp_pkg::BGP_ACC_WRITE && wr_oeclr == 4'h0
        && wr_oeset == 4'h0 |=> $stable(gpio_oe))
        else $error("zero enable write changed direction");

    a_input_follows: assert property ($stable(gpio_in)[*3] ##0 acc == bgp_pkg::BGP_ACC_READ
        && hit |=> cfg_rdata[31:28] == $past(gpio_in))
        else $error("input field does not show pin levels");

    a_reserved_zero: assert property (cfg_rack |-> cfg_rdata[27:24] == 4'h0)
        else $error("reserved nibble read nonzero");

    a_reset_clears: assert property ($past(rst) |-> gpio_oe == 4'h0 && gpio_out == 4'h0)
        else $error("pins not cleared after reset");

    a_input_undriven: assert property (acc == bgp_pkg::BGP_ACC_WRITE |=>
        (gpio_oe & ~$past(gpio_oe) & ~$past(wr_oeset)) == 4'h0)
        else $error("input-only pin started driving without enable set");

    a_data_readback: assert property ((acc == bgp_pkg::BGP_ACC_WRITE && cfg_be[1]) ##1 s_quiet_read |=>
        (cfg_rdata & 32'h0000_ff00) == ($past(cfg_wdata, 5) & 32'h0000_ff00))
        else $error("data fields do not read back last write");

    a_dir_readback: assert property ((acc == bgp_pkg::BGP_ACC_WRITE && cfg_be[2]) ##1 s_quiet_read |=>
        (cfg_rdata & 32'h00ff_0000) == ($past(cfg_wdata, 5) & 32'h00ff_0000))
        else $error("enable fields do not read back last write");

endmodule

// >>> test/bgp_pin_model.sv
`timescale 1ns/100ps

// Far-side devices sharing the four general-purpose pins
module bgp_pin_model
(
    input  wire logic [3:0] gpio_out,  // Port output value
    input  wire logic [3:0] gpio_oe,   // Port drive enable
    input  wire logic [3:0] ext_val,   // Level the devices put on released pins
    output logic      [3:0] gpio_in    // Resolved pin level
);
    // Devices drive only the pins that the port has released, so no pin fights
    assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ext_val);
endmodule

// >>> test/tb_top.sv
`timescale 1ns/100ps

// Self-checking bench for the general-purpose port
module tb_top;
    logic        ref_clk   = 1'b0;    // 100 MHz clock
    logic        rst       = 1'b1;    // Synchronous reset
    logic [7:0]  cfg_addr  = 8'h00;   // Configuration address
    logic [3:0]  cfg_be    = 4'h0;    // Byte enables
    logic [31:0] cfg_wdata = 32'h0;   // Write data
    logic        cfg_wr    = 1'b0;    // Write completion pulse
    logic        cfg_rd    = 1'b0;    // Read request pulse
    logic [31:0] cfg_rdata;           // Read data
    logic        cfg_rack;            // Read answer
    logic [3:0]  gpio_in;             // Resolved pins
    logic [3:0]  gpio_out;            // Output value
    logic [3:0]  gpio_oe;             // Output enable
    logic [3:0]  ext_val   = 4'h5;    // Far-side level
    logic [3:0]  m_out     = 4'h0;    // Expected output value
    logic [3:0]  m_oe      = 4'h0;    // Expected enables
    logic [15:0] m_lane    = 16'h0;   // Expected readback of bits 23:8
    logic [31:0] exp_q[$];            // Expected read answers
    int          error_cnt = 0;       // Mismatches
    int          n_compared = 0;      // Comparisons made

    // Clock
    always #5 ref_clk = ~ref_clk;

    bgp_gpio_port bgp_gpio_port_inst
    (
        .ref_clk(ref_clk), .rst(rst), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
        .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
        .cfg_rack(cfg_rack), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe)
    );

    bgp_pin_model bgp_pin_model_inst
    (
        .gpio_out(gpio_out), .gpio_oe(gpio_oe), .ext_val(ext_val), .gpio_in(gpio_in)
    );

    // Compare one value and count it
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask

    // Verdict and end of run
    task automatic results();
        if (error_cnt == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // One write; outputs are looked at in the cycle after it completes
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge ref_clk);
        #1;
        cfg_addr = a;
        cfg_be = be;
        cfg_wdata = d;
        cfg_wr = 1'b1;
        // Only the port's own dword changes state; set wins over clear
        if (a[7:2] == 6'h19 && be[1])
        begin
            m_lane[7:0] = d[15:8];
            m_out = (m_out & ~d[11:8]) | d[15:12];
        end
        if (a[7:2] == 6'h19 && be[2])
        begin
            m_lane[15:8] = d[23:16];
            m_oe = (m_oe & ~d[19:16]) | d[23:20];
        end
        @(posedge ref_clk);
        #1;
        cfg_wr = 1'b0;
        chk("gpio_out", 32'(m_out), 32'(gpio_out));
        chk("gpio_oe", 32'(m_oe), 32'(gpio_oe));
        chk("pins", 32'((m_oe & m_out) | (~m_oe & ext_val)), 32'(gpio_in));
    endtask

    // One read; waits first so pin levels have crossed the synchroniser
    task automatic rd(input logic [7:0] a);
        repeat (3) @(posedge ref_clk);
        #1;
        cfg_addr = a;
        cfg_rd = 1'b1;
        exp_q.push_back(a[7:2] == 6'h19 ? {(m_oe & m_out) | (~m_oe & ext_val), 4'h0, m_lane, 8'h00} : 32'h0);
        @(posedge ref_clk);
        #1;
        cfg_rd = 1'b0;
    endtask

    // Monitor: every read answer takes the oldest note
    always @(negedge ref_clk)
        if (cfg_rack === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk("cfg_rack", 32'h0, 32'h1);
            else
                chk("cfg_rdata", exp_q.pop_front(), cfg_rdata);
        end

    // Watchdog: about 300 cycles of work, allowed 2000
    initial
    begin
        #20000;
        chk("timeout", 32'h0, 32'h1);
        results();
    end

    // Main sequence
    initial
    begin
        void'($urandom(36));
        repeat (10) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        chk("out_reset", 32'h0, 32'(gpio_out));
        chk("oe_reset", 32'h0, 32'(gpio_oe));
        rd(8'h64);
        wr(8'h64, 4'h2, 32'h0000_f000);
        wr(8'h64, 4'h4, 32'h0030_0000);
        wr(8'h64, 4'h2, 32'h0000_0100);
        wr(8'h64, 4'h6, 32'h0000_0000);
        rd(8'h64);
        wr(8'h64, 4'h2, 32'h0000_1000);
        wr(8'h64, 4'h9, 32'hffff_ffff);
        wr(8'h64, 4'h4, 32'h0001_0000);
        wr(8'h60, 4'hf, 32'hffff_ffff);
        rd(8'h60);
        ext_val = 4'ha;
        rd(8'h64);
        repeat (40)
        begin
            ext_val = 4'($urandom);
            wr(8'h64, 4'($urandom), $urandom);
            rd(8'h64);
        end
        rst = 1'b1;
        @(posedge ref_clk);
        #1;
        rst = 1'b0;
        m_out = 4'h0;
        m_oe = 4'h0;
        m_lane = 16'h0;
        chk("out_reset", 32'h0, 32'(gpio_out));
        chk("oe_reset", 32'h0, 32'(gpio_oe));
        rd(8'h64);
        repeat (4) @(posedge ref_clk);
        chk("pending", 32'h0, 32'(exp_q.size()));
        results();
    end
endmodule
